// ==== hw/fbe_cfg.svh ====
// constants for the memory bit error reporting block
//
// Overview of operation
// - detecting an uncorrectable read error sets the uncorrectable error flag.
// - with reset enable set, uncorrectable error forces warm reset and loads reset cause code.
// - with uncorrectable irq enable set and reset enable clear, uncorrectable error requests NMI with its vector code.
// - with correctable irq enable set, correctable error without an uncorrectable one sets its flag and requests NMI.
// - uncorrectable flag survives the warm reset it caused, readable afterwards.
`ifndef FBE_CFG_SVH
`define FBE_CFG_SVH

// register byte offsets
`define FBE_OFS_CONFIG  8'h00
`define FBE_OFS_FLAGS   8'h04
`define FBE_OFS_RSTIV   8'h08
`define FBE_OFS_NMIIV   8'h0C
`define FBE_OFS_IRQ_ST  8'h10
`define FBE_OFS_IRQ_MSK 8'h14

// config word fields
`define FBE_BIT_URSTEN  0
`define FBE_BIT_UIE     1
`define FBE_BIT_CIE     2
// flag word and irq status fields
`define FBE_BIT_UFLAG   0
`define FBE_BIT_CFLAG   1

// vector codes (plain defaults)
`define FBE_CODE_NONE   16'h0000
`define FBE_CODE_URST   16'h0018
`define FBE_CODE_UNMI   16'h0004
`define FBE_CODE_CNMI   16'h0002

// warm reset pulse length
`define FBE_RST_NS      16
`define FBE_CLK_NS      4
`define FBE_RST_CYC     ((`FBE_RST_NS + `FBE_CLK_NS - 1) / `FBE_CLK_NS)

`endif

// ==== hw/fbe_pkg.sv ====
// types for the memory bit error reporting block
`default_nettype none
package fbe_pkg;
  typedef struct packed {
    logic        valid;   // one read access completes
    logic        uncorr;  // uncorrectable error seen
    logic        corr;    // correctable error seen
  } fbe_det_t;
endpackage : fbe_pkg
`default_nettype wire

// ==== hw/fbe_top.sv ====
// memory bit error reporting with ahb-lite register slave
`include "fbe_cfg.svh"
`default_nettype none
module fbe_top (
  // clock and warm reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_rstn,
  // power-on reset, clears the sticky flag
  input  wire logic            i_por_rstn,
  // detection result from the memory read path
  input  wire fbe_pkg::fbe_det_t i_det,
  // ahb-lite slave
  input  wire logic            i_hsel,
  input  wire logic [7:0]      i_haddr,
  input  wire logic [1:0]      i_htrans,
  input  wire logic            i_hwrite,
  input  wire logic [2:0]      i_hsize,
  input  wire logic [31:0]     i_hwdata,
  input  wire logic            i_hready,
  output logic [31:0]          o_hrdata,
  output logic                 o_hreadyout,
  output logic                 o_hresp,
  // system outputs
  output logic                 o_warm_rst_req,
  output logic                 o_nmi_req,
  output logic                 o_irq
);

  ////////////////////////////////////////////////////////////////
  // registers
  logic [2:0]  cfg_reg;
  logic        uflag_reg;
  logic        cflag_reg;
  logic [15:0] rstiv_reg;
  logic [15:0] nmiiv_reg;
  logic [1:0]  ist_reg;
  logic [1:0]  imsk_reg;
  logic [2:0]  rst_cnt_reg;
  logic        nmi_reg;
  logic        wr_ph_reg;
  logic [7:0]  addr_ph_reg;

  ////////////////////////////////////////////////////////////////
  // bus decode
  // a warm reset in mid-transfer drops the transfer, so it cannot clear
  // the sticky flag or the cause vector that the reset must preserve
  wire bus_req = i_rstn & i_hsel & i_hready & i_htrans[1];
  wire wr_live = i_rstn & wr_ph_reg;
  wire wr_cfg  = wr_live & (addr_ph_reg == `FBE_OFS_CONFIG);
  wire wr_flg  = wr_live & (addr_ph_reg == `FBE_OFS_FLAGS);
  wire wr_ist  = wr_live & (addr_ph_reg == `FBE_OFS_IRQ_ST);
  wire wr_msk  = wr_live & (addr_ph_reg == `FBE_OFS_IRQ_MSK);
  wire rd_rsv  = bus_req & ~i_hwrite & (i_haddr == `FBE_OFS_RSTIV);
  wire rd_nmv  = bus_req & ~i_hwrite & (i_haddr == `FBE_OFS_NMIIV);

  // one event per access, uncorrectable wins
  wire ev_u = i_det.valid & i_det.uncorr;
  wire ev_c = i_det.valid & i_det.corr & ~i_det.uncorr;
  wire ev_c_en = ev_c & cfg_reg[`FBE_BIT_CIE];
  wire ev_rst  = ev_u & cfg_reg[`FBE_BIT_URSTEN];
  wire ev_unmi = ev_u & cfg_reg[`FBE_BIT_UIE] & ~cfg_reg[`FBE_BIT_URSTEN];

  // irq status next value; a new event beats its own write-one-to-clear
  wire [1:0] ist_next = (ist_reg & ~({2{wr_ist}} & i_hwdata[1:0])) | {ev_c_en, ev_u};

  // read mux; vectors clear on read like classic iv registers
  wire [31:0] rd_mux =
    (i_haddr == `FBE_OFS_CONFIG)  ? {29'h0, cfg_reg} :
    (i_haddr == `FBE_OFS_FLAGS)   ? {30'h0, cflag_reg, uflag_reg} :
    (i_haddr == `FBE_OFS_RSTIV)   ? {16'h0, rstiv_reg} :
    (i_haddr == `FBE_OFS_NMIIV)   ? {16'h0, nmiiv_reg} :
    (i_haddr == `FBE_OFS_IRQ_ST)  ? {30'h0, ist_reg} :
    (i_haddr == `FBE_OFS_IRQ_MSK) ? {30'h0, imsk_reg} : 32'h0;

  assign o_hreadyout    = 1'b1;
  assign o_hresp        = 1'b0;
  assign o_warm_rst_req = (rst_cnt_reg != 3'h0);
  assign o_nmi_req      = nmi_reg;
  assign o_irq          = |(ist_reg & imsk_reg);

  ////////////////////////////////////////////////////////////////
  // bus phase capture and read data
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      wr_ph_reg   <= 1'b0;
      addr_ph_reg <= 8'h00;
      o_hrdata    <= 32'h0;
    end else begin
      wr_ph_reg   <= bus_req & i_hwrite;
      addr_ph_reg <= i_haddr;
      if (bus_req & ~i_hwrite) begin
        o_hrdata <= rd_mux;
      end
    end
  end

  // sticky uncorrectable flag lives on power-on reset, not warm reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_rstn) begin
      uflag_reg <= 1'b0;
    end else if (ev_u) begin
      uflag_reg <= 1'b1;
    end else if (wr_flg & i_hwdata[`FBE_BIT_UFLAG]) begin
      uflag_reg <= 1'b0;
    end
  end

  // reset cause vector also survives the warm reset it reports
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_rstn) begin
      rstiv_reg <= `FBE_CODE_NONE;
    end else if (ev_rst) begin
      rstiv_reg <= `FBE_CODE_URST;
    end else if (rd_rsv) begin
      rstiv_reg <= `FBE_CODE_NONE;
    end
  end

  // config word and irq mask are plain storage
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cfg_reg  <= 3'h0;
      imsk_reg <= 2'h0;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= i_hwdata[2:0];
      end
      if (wr_msk) begin
        imsk_reg <= i_hwdata[1:0];
      end
    end
  end

  // correctable flag; an event in the clearing cycle keeps it set
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cflag_reg <= 1'b0;
    end else if (ev_c_en) begin
      cflag_reg <= 1'b1;
    end else if (wr_flg & i_hwdata[`FBE_BIT_CFLAG]) begin
      cflag_reg <= 1'b0;
    end
  end

  // irq status, next value worked out in the decode section
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ist_reg <= 2'h0;
    end else begin
      ist_reg <= ist_next;
    end
  end

  // nmi vector holds the latest source until software reads it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      nmiiv_reg <= `FBE_CODE_NONE;
    end else if (ev_unmi) begin
      nmiiv_reg <= `FBE_CODE_UNMI;
    end else if (ev_c_en) begin
      nmiiv_reg <= `FBE_CODE_CNMI;
    end else if (rd_nmv) begin
      nmiiv_reg <= `FBE_CODE_NONE;
    end
  end

  // nmi request is a single-cycle pulse per enabled event
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      nmi_reg <= 1'b0;
    end else begin
      nmi_reg <= ev_unmi | ev_c_en;
    end
  end

  // warm reset request; a fresh error reloads the full pulse length
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rst_cnt_reg <= 3'h0;
    end else if (ev_rst) begin
      rst_cnt_reg <= 3'(`FBE_RST_CYC);
    end else if (rst_cnt_reg != 3'h0) begin
      rst_cnt_reg <= rst_cnt_reg - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // assertions
  // the sticky flag and the cause vector are checked against power-on reset,
  // apart from the cause check in warm_rst_req_a, since they must ride through the warm reset they request
  uerr_sets_flag_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_rstn)
    ev_u |=> uflag_reg) else $error("uncorrectable flag not set");
  warm_rst_req_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ev_rst |=> o_warm_rst_req && rstiv_reg == `FBE_CODE_URST) else $error("warm reset missing");
  unmi_vector_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ev_unmi |=> o_nmi_req && nmiiv_reg == `FBE_CODE_UNMI) else $error("uncorr nmi missing");
  cnmi_flag_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ev_c_en |=> cflag_reg && o_nmi_req && nmiiv_reg == `FBE_CODE_CNMI) else $error("corr nmi missing");
  flag_survive_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_rstn)
    uflag_reg && !i_rstn |=> uflag_reg) else $error("flag lost in warm reset");
  flag_hold_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    cflag_reg && !wr_flg |=> cflag_reg) else $error("corr flag dropped");
  single_event_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_det.valid && i_det.uncorr && i_det.corr |=> !cflag_reg || $past(cflag_reg))
    else $error("correctable taken with uncorrectable");
  nmi_pulse_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !ev_unmi && !ev_c_en |=> !o_nmi_req) else $error("spurious nmi");
  rst_len_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ev_rst |=> o_warm_rst_req [*4]) else $error("reset pulse too short");
  rst_end_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ev_rst ##1 !ev_rst [*4] |=> !o_warm_rst_req) else $error("reset pulse too long");
  cause_kept_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_rstn)
    rstiv_reg == `FBE_CODE_URST && !rd_rsv |=> rstiv_reg == `FBE_CODE_URST) else $error("reset cause lost");
  cflag_gated_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !ev_c_en && !cflag_reg |=> !cflag_reg) else $error("corr flag set without enable");
  uflag_hold_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_rstn)
    uflag_reg && !(wr_flg && i_hwdata[`FBE_BIT_UFLAG]) |=> uflag_reg) else $error("uncorr flag dropped");
  status_prio_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_det.valid && i_det.uncorr |=> !ist_reg[`FBE_BIT_CFLAG] || $past(ist_reg[`FBE_BIT_CFLAG]))
    else $error("corr status taken with uncorrectable");
  irq_follows_a : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ev_u && imsk_reg[`FBE_BIT_UFLAG] && !wr_msk |=> o_irq) else $error("unmasked irq missing");

endmodule : fbe_top
`default_nettype wire

// ==== bench/fbe_mem_model.sv ====
// memory read path model, one detection result per access after a chosen latency
`default_nettype none
module fbe_mem_model (
  // clock
  input  wire logic             i_clk_sys,
  // access request from the bench
  input  wire logic             i_go,
  input  wire logic             i_unc,
  input  wire logic             i_cor,
  input  wire logic [2:0]       i_lat,
  // detection result towards the block
  output var fbe_pkg::fbe_det_t o_det
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt  = 3'h0;
  logic [1:0] kind = 2'h0;
  logic       busy = 1'b0;
  logic       tog  = 1'b0;
  initial o_det = '0;
  // qualifiers toggle while idle, so a block that ignores valid is caught
  always @(posedge i_clk_sys) begin
    tog   <= ~tog;
    o_det <= '{1'b0, tog, ~tog};
    if (i_go) begin
      {busy, cnt, kind} <= {1'b1, i_lat, i_unc, i_cor};
    end else if (busy && cnt == 3'h0) begin
      o_det <= '{1'b1, kind[1], kind[0]};
      busy  <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule : fbe_mem_model
`default_nettype wire

// ==== bench/fbe_top_bench.sv ====
// self-checking bench for the memory bit error reporting block
`include "fbe_cfg.svh"
`default_nettype none
module fbe_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, unc = 1'b0, cor = 1'b0;
  logic [7:0]  haddr  = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  lat = 3'h0, cfg;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hready, hresp, warm, nmi, irq, u, c;
  fbe_pkg::fbe_det_t det;
  int failures = 0, comparisons = 0, seed = 25, nmi_n = 0, warm_n = 0, n0, w0;
  always #2 clk = ~clk;
  // pulse and level counters, sampled at each rising edge
  always @(posedge clk) begin
    nmi_n  += (nmi === 1'b1);
    warm_n += (warm === 1'b1);
  end
  fbe_mem_model u_fbe_mem_model (.i_clk_sys(clk), .i_go(go), .i_unc(unc), .i_cor(cor), .i_lat(lat), .o_det(det));
  fbe_top u_fbe_top (.i_clk_sys(clk), .i_rstn(rst_n), .i_por_rstn(por_n), .i_det(det), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_warm_rst_req(warm), .o_nmi_req(nmi), .o_irq(irq));
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // bounded wait on an edge where the slave shows ready; a hang ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin failures++; report_and_stop(); end
  endtask : wait_ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    wait_ready();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  // one read access; the wait after it covers the whole warm request
  task automatic access(input logic iu, input logic ic, input logic [2:0] l);
    int n;
    go <= 1'b1; unc <= iu; cor <= ic; lat <= l;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (det.valid !== 1'b1 && n < 16);
    if (det.valid !== 1'b1) begin failures++; report_and_stop(); end
    repeat (8) @(posedge clk);
  endtask : access
  function automatic logic [31:0] exp_flags(input logic [2:0] k, input logic iu, input logic ic);
    return {30'h0, ic & ~iu & k[`FBE_BIT_CIE], iu};
  endfunction : exp_flags
  function automatic logic [31:0] exp_vec(input logic [2:0] k, input logic iu, input logic ic);
    if (iu) return (k[`FBE_BIT_UIE] & ~k[`FBE_BIT_URSTEN]) ? 32'(`FBE_CODE_UNMI) : 32'h0;
    return (ic & k[`FBE_BIT_CIE]) ? 32'(`FBE_CODE_CNMI) : 32'h0;
  endfunction : exp_vec
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1; por_n <= 1'b1;
    @(posedge clk);
    // reset values, unmapped words included
    for (int a = 0; a < 32; a += 4) begin bus(1'b0, 8'(a), 32'h0); chk("reset value", 32'h0, rd); end
    // random accesses with random irq enables, reset enable off; first one has both kinds at once
    for (int i = 0; i < 16; i++) begin
      cfg = (i == 0) ? 3'h6 : 3'($random(seed)) & 3'h6;
      {u, c} = (i == 0) ? 2'h3 : 2'($random(seed));
      bus(1'b1, `FBE_OFS_CONFIG, 32'(cfg));
      n0 = nmi_n;
      access(u, c, 3'($random(seed)));
      chk("nmi pulses", 32'(exp_vec(cfg, u, c) != 0), 32'(nmi_n - n0));
      bus(1'b0, `FBE_OFS_FLAGS, 32'h0);
      chk("flags", exp_flags(cfg, u, c), rd);
      bus(1'b0, `FBE_OFS_NMIIV, 32'h0);
      chk("nmi vector", exp_vec(cfg, u, c), rd);
      bus(1'b1, `FBE_OFS_FLAGS, 32'h0);
      bus(1'b0, `FBE_OFS_FLAGS, 32'h0);
      chk("flags kept", exp_flags(cfg, u, c), rd);
      bus(1'b1, `FBE_OFS_FLAGS, 32'h3);
      bus(1'b1, `FBE_OFS_IRQ_ST, 32'h3);
    end
    // interrupt raised while masked, then unmasked, then cleared
    bus(1'b1, `FBE_OFS_CONFIG, 32'h0);
    access(1'b1, 1'b0, 3'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `FBE_OFS_IRQ_MSK, 32'h1);
    @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, `FBE_OFS_IRQ_ST, 32'h1);
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, `FBE_OFS_FLAGS, 32'h3);
    // sleep entry with enables off; a false error on the first access after wake-up
    bus(1'b1, `FBE_OFS_CONFIG, 32'h0);
    n0 = nmi_n;
    w0 = warm_n;
    access(1'b1, 1'b1, 3'h2);
    chk("sleep no nmi", 32'h0, 32'(nmi_n - n0));
    chk("sleep no warm", 32'h0, 32'(warm_n - w0));
    bus(1'b0, `FBE_OFS_FLAGS, 32'h0);
    chk("sleep flag", 32'h1, rd);
    bus(1'b0, `FBE_OFS_NMIIV, 32'h0);
    chk("sleep vector", 32'h0, rd);
    bus(1'b1, `FBE_OFS_FLAGS, 32'h3);
    bus(1'b1, `FBE_OFS_IRQ_ST, 32'h3);
    bus(1'b0, `FBE_OFS_FLAGS, 32'h0);
    chk("flags after wake", 32'h0, rd);
    // warm reset path: reset wins over the nmi, flag outlives the reset
    bus(1'b1, `FBE_OFS_CONFIG, 32'h3);
    w0 = warm_n;
    n0 = nmi_n;
    access(1'b1, 1'b0, 3'h5);
    chk("warm cycles", `FBE_RST_CYC, 32'(warm_n - w0));
    chk("nmi in reset", 32'h0, 32'(nmi_n - n0));
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `FBE_OFS_FLAGS, 32'h0);
    chk("flag after reset", 32'h1, rd);
    bus(1'b0, `FBE_OFS_RSTIV, 32'h0);
    chk("reset cause", 32'(`FBE_CODE_URST), rd);
    bus(1'b0, `FBE_OFS_RSTIV, 32'h0);
    chk("cause cleared", 32'(`FBE_CODE_NONE), rd);
    report_and_stop();
  end
endmodule : fbe_top_bench
`default_nettype wire
